/* hw/sewp_pkg.sv */
package sewp_pkg;

  // Fixed device-type code carried in the top nibble of the control byte.
  localparam logic [3:0]  SEWP_TYPE_CODE     = 4'ha;
  localparam int          SEWP_ADDR_W        = 11;
  localparam int          SEWP_DATA_W        = 8;
  localparam int          SEWP_PAGE_BYTES    = 16;
  localparam int          SEWP_FIFO_DEPTH    = 16;
  localparam int          SEWP_CLK_MHZ       = 125;
  localparam int          SEWP_WRITE_MS      = 5;
  // Longest write time counted in whole cycles.
  localparam int          SEWP_WRITE_CYC     =
    SEWP_WRITE_MS * 1000 * SEWP_CLK_MHZ;
  localparam logic [SEWP_ADDR_W-1:0] SEWP_ADDR_RST = 11'h000;
  localparam logic [SEWP_DATA_W-1:0] SEWP_BYTE_RST = 8'h00;

  typedef enum logic [2:0] {
    SEWP_IDLE,
    SEWP_CTRL,
    SEWP_WADDR,
    SEWP_WDATA,
    SEWP_RDATA,
    SEWP_RACK,
    SEWP_IGNORE
  } sewp_phase_type;

  // One array write request leaving the page buffer.
  typedef struct packed {
    logic [SEWP_ADDR_W-1:0] addr;
    logic [SEWP_DATA_W-1:0] data;
  } sewp_word_type;

endpackage

/* hw/sewp_fifo.sv */
module sewp_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sewp_fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } sewp_fifo_st_type;

  sewp_fifo_st_type st_r;
  sewp_fifo_st_type st_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready_out  = (st_r.wr - st_r.rd) != (AW+1)'(DEPTH);
  assign out_valid_out = st_r.wr != st_r.rd;
  assign out_data_out  = mem_r[st_r.rd[AW-1:0]];
  assign push          = ce_in && in_valid_in && in_ready_out;
  assign pop           = ce_in && out_valid_out && out_ready_in;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wr = st_r.wr + 1'b1;
    end
    if (pop) begin
      st_nxt.rd = st_r.rd + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[st_r.wr[AW-1:0]] <= in_data_in;
    end
  end
endmodule

/* hw/sewp_top.sv */
// Summary of operation
// - Data changes only with clock low; high-clock edges mean start/stop.
// - Data falling while clock high is a start; begin control byte.
// - Data rising while clock high is a stop; transfer ends.
// - One bit per clock pulse, sampled on the rising clock edge.
// - Receiver acknowledges each byte in a ninth clock pulse.
// - Acknowledger holds data low throughout the acknowledge high phase.
// - No acknowledge at all while the internal write cycle runs.
// - Master not acknowledging a read byte makes the device release data.
// - Acknowledge control byte only when its top nibble is 1010.
// - Three block bits form the top of the 11-bit word address.
// - Control byte bit 0 high means read, low means write.
// - Byte write: control, word address into pointer, one data byte.
// - Array commit starts only at the stop after write data.
// - Page buffer holds up to 16 bytes until the stop.
// - Each written byte increments only the low four pointer bits.
// - More than 16 bytes wrap and overwrite oldest buffer entries.
// - Page writes wrap within the same 16-byte page.
// - Write-protect high when the control byte is accepted inhibits that transfer's array writes; reads still work.
// - The three select pins are ignored completely.
// - Master owns clock, start and stop; device is slave only.
// - The internal write cycle finishes within 5 ms.
// - Address counter holds last accessed address plus one.
module sewp_top
  import sewp_pkg::*;
#(
  parameter int WRITE_CYC = SEWP_WRITE_CYC
) (
  // Clock, reset and enable
  input  wire logic                   SYS_CLK_IN,
  input  wire logic                   RST_N_IN,
  input  wire logic                   CE_IN,
  // Two-wire bus
  input  wire logic                   SCL_IN,
  input  wire logic                   SDA_IN,
  output logic                        SDA_OUT,
  output logic                        SDA_OE_OUT,
  // Pins
  input  wire logic                   WRITE_PROTECT_IN,
  input  wire logic                   UNUSED_SELECT_PIN_0_IN,
  input  wire logic                   UNUSED_SELECT_PIN_1_IN,
  input  wire logic                   UNUSED_SELECT_PIN_2_IN,
  // Array port
  output sewp_pkg::sewp_word_type     ARRAY_WR_OUT,
  output logic                        ARRAY_WR_VALID_OUT,
  input  wire logic                   ARRAY_WR_READY_IN,
  output logic [SEWP_ADDR_W-1:0]      ARRAY_RD_ADDR_OUT,
  input  wire logic [SEWP_DATA_W-1:0] ARRAY_RD_DATA_IN,
  // Status
  output logic                        BUSY_OUT,
  output logic [SEWP_ADDR_W-1:0]      ADDR_PTR_OUT
);
  import sewp_pkg::*;

  localparam int PW = $clog2(SEWP_PAGE_BYTES);
  localparam int TW = $clog2(WRITE_CYC + 1);

  if (WRITE_CYC < 1) begin : g_bad_write_cyc
    $error("sewp_top write time must be at least one cycle");
  end

  typedef struct packed {
    logic [1:0]             scl_s;
    logic [1:0]             sda_s;
    logic                   scl_d;
    logic                   sda_d;
    sewp_phase_type         phase;
    logic [3:0]             bit_cnt;
    logic [SEWP_DATA_W-1:0] shift;
    logic                   ack_slot;
    logic                   ack_drive;
    logic                   sda_o;
    logic                   sda_oe;
    logic [SEWP_ADDR_W-1:0] ptr;
    logic [PW:0]            count;
    logic                   wp_latched;
    logic [1:0]             wp_s;
    logic [PW-1:0]          first;
    logic [PW-1:0]          base;
    logic                   commit;
    logic [PW:0]            drain;
    logic                   busy;
    logic [TW-1:0]          timer;
  } sewp_st_type;

  sewp_st_type                    st_r;
  sewp_st_type                    st_nxt;
  logic [SEWP_DATA_W-1:0]         page_r [SEWP_PAGE_BYTES];
  logic [SEWP_ADDR_W-1:0]         page_addr_r [SEWP_PAGE_BYTES];
  logic                           scl;
  logic                           sda;
  logic                           scl_rise;
  logic                           scl_fall;
  logic                           start_c;
  logic                           stop_c;
  logic                           page_we;
  logic [PW-1:0]                  page_idx;
  logic                           fifo_valid;
  logic                           fifo_ready;
  sewp_word_type                  fifo_in;
  logic [PW-1:0]                  drain_idx;
  logic                           unused_pins;

  // The select pins reach nothing by design.
  assign unused_pins = UNUSED_SELECT_PIN_0_IN ^ UNUSED_SELECT_PIN_1_IN
                     ^ UNUSED_SELECT_PIN_2_IN;

  assign scl      = st_r.scl_s[1];
  assign sda      = st_r.sda_s[1];
  assign scl_rise = scl && !st_r.scl_d;
  assign scl_fall = !scl && st_r.scl_d;
  assign start_c  = scl && st_r.scl_d && st_r.sda_d && !sda;
  assign stop_c   = scl && st_r.scl_d && !st_r.sda_d && sda;
  assign page_idx = st_r.ptr[PW-1:0];
  assign drain_idx = st_r.base + st_r.drain[PW-1:0];
  assign fifo_valid = st_r.commit && (st_r.drain != st_r.count);
  assign fifo_in.addr = page_addr_r[drain_idx];
  assign fifo_in.data = page_r[drain_idx];

  always_comb begin
    st_nxt = st_r;
    page_we = 1'b0;
    st_nxt.scl_s = {st_r.scl_s[0], SCL_IN};
    st_nxt.sda_s = {st_r.sda_s[0], SDA_IN};
    st_nxt.scl_d = scl;
    st_nxt.sda_d = sda;
    // The protect pin is a board level, so it is synchronised like the bus.
    st_nxt.wp_s = {st_r.wp_s[0], WRITE_PROTECT_IN};

    // Commit: page buffer drains into the array FIFO while the timer runs.
    if (st_r.commit) begin
      if (fifo_valid && fifo_ready) begin
        st_nxt.drain = st_r.drain + 1'b1;
      end else if (!fifo_valid) begin
        st_nxt.commit = 1'b0;
      end
    end
    if (st_r.busy) begin
      if (st_r.timer == TW'(WRITE_CYC - 1)) begin
        st_nxt.busy = 1'b0;
        st_nxt.timer = '0;
      end else begin
        st_nxt.timer = st_r.timer + 1'b1;
      end
    end

    if (start_c) begin
      st_nxt.phase = SEWP_CTRL;
      st_nxt.bit_cnt = '0;
      st_nxt.ack_slot = 1'b0;
      st_nxt.ack_drive = 1'b0;
      st_nxt.sda_oe = 1'b0;
      st_nxt.count = '0;
    end else if (stop_c) begin
      // Uncommitted writes are dropped if protect was high.
      if (st_r.phase == SEWP_WDATA && st_r.count != '0
          && !st_r.wp_latched && !st_r.busy) begin
        st_nxt.commit = 1'b1;
        st_nxt.busy = 1'b1;
        st_nxt.drain = '0;
        // A full page drains from slot 0, a partial one from its first slot.
        st_nxt.base = (st_r.count == (PW+1)'(SEWP_PAGE_BYTES))
                    ? '0 : st_r.first;
        st_nxt.timer = '0;
      end
      st_nxt.phase = SEWP_IDLE;
      st_nxt.sda_oe = 1'b0;
      st_nxt.ack_slot = 1'b0;
    end else if (st_r.phase != SEWP_IDLE && st_r.phase != SEWP_IGNORE) begin
      if (scl_rise) begin
        // Bits are sampled on the rising edge of the clock.
        if (!st_r.ack_slot && st_r.phase != SEWP_RDATA) begin
          st_nxt.shift = {st_r.shift[SEWP_DATA_W-2:0], sda};
          st_nxt.bit_cnt = st_r.bit_cnt + 1'b1;
        end else if (st_r.phase == SEWP_RACK) begin
          st_nxt.phase = sda ? SEWP_IGNORE : SEWP_RDATA;
        end
      end else if (scl_fall) begin
        // Outputs change only while the clock is low.
        if (st_r.ack_slot) begin
          st_nxt.ack_slot = 1'b0;
          st_nxt.bit_cnt = '0;
          st_nxt.sda_oe = 1'b0;
          if (st_nxt.phase == SEWP_RDATA) begin
            st_nxt.sda_o = 1'b0;
            st_nxt.sda_oe = !ARRAY_RD_DATA_IN[SEWP_DATA_W-1];
            st_nxt.shift = {ARRAY_RD_DATA_IN[SEWP_DATA_W-2:0], 1'b1};
            st_nxt.ptr = st_r.ptr + 1'b1;
          end
        end else if (st_r.phase == SEWP_RDATA
                     && st_r.bit_cnt != 4'h8) begin
          st_nxt.sda_oe = !st_r.shift[SEWP_DATA_W-1];
          st_nxt.shift = {st_r.shift[SEWP_DATA_W-2:0], 1'b1};
          st_nxt.bit_cnt = st_r.bit_cnt + 1'b1;
          // After the last bit the line is freed for the master's answer.
          if (st_r.bit_cnt == 4'h7) begin
            st_nxt.sda_oe = 1'b0;
            st_nxt.ack_slot = 1'b1;
            st_nxt.phase = SEWP_RACK;
          end
        end else if (st_r.bit_cnt == 4'h8) begin
          st_nxt.ack_slot = 1'b1;
          st_nxt.sda_oe = 1'b0;
          case (st_r.phase)
            SEWP_CTRL: begin
              if (st_r.shift[7:4] != SEWP_TYPE_CODE || st_r.busy
                  || st_r.commit) begin
                st_nxt.phase = SEWP_IGNORE;
                st_nxt.ack_slot = 1'b0;
              end else begin
                st_nxt.ptr[10:8] = st_r.shift[3:1];
                st_nxt.sda_oe = 1'b1;
                st_nxt.sda_o = 1'b0;
                st_nxt.wp_latched = st_r.wp_s[1];
                if (st_r.shift[0]) begin
                  st_nxt.phase = SEWP_RDATA;
                  st_nxt.bit_cnt = 4'h8;
                end else begin
                  st_nxt.phase = SEWP_WADDR;
                end
              end
            end
            SEWP_WADDR: begin
              st_nxt.ptr[7:0] = st_r.shift;
              st_nxt.first = st_r.shift[PW-1:0];
              st_nxt.sda_oe = 1'b1;
              st_nxt.phase = SEWP_WDATA;
            end
            SEWP_WDATA: begin
              page_we = 1'b1;
              if (st_r.count != (PW+1)'(SEWP_PAGE_BYTES)) begin
                st_nxt.count = st_r.count + 1'b1;
              end
              st_nxt.ptr[PW-1:0] = page_idx + 1'b1;
              st_nxt.sda_oe = 1'b1;
            end
            SEWP_RDATA: begin
              st_nxt.phase = SEWP_RACK;
              st_nxt.sda_oe = 1'b0;
            end
            default: begin
              st_nxt.ack_slot = 1'b0;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_r <= '{scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1,
                phase: SEWP_IDLE, ptr: SEWP_ADDR_RST,
                shift: SEWP_BYTE_RST, sda_o: 1'b1, default: '0};
    end else if (CE_IN) begin
      st_r <= st_nxt;
    end
  end

  // A later byte at the same page slot replaces the older one.
  always_ff @(posedge SYS_CLK_IN) begin
    if (CE_IN && page_we) begin
      page_r[page_idx] <= st_r.shift;
      page_addr_r[page_idx] <= st_r.ptr;
    end
  end

  sewp_fifo #(
    .WIDTH ($bits(sewp_word_type)),
    .DEPTH (SEWP_FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (SYS_CLK_IN),
    .rst_n_in      (RST_N_IN),
    .ce_in         (CE_IN),
    .in_valid_in   (fifo_valid),
    .in_ready_out  (fifo_ready),
    .in_data_in    (fifo_in),
    .out_valid_out (ARRAY_WR_VALID_OUT),
    .out_ready_in  (ARRAY_WR_READY_IN),
    .out_data_out  (ARRAY_WR_OUT)
  );

  assign SDA_OUT           = st_r.sda_o;
  assign SDA_OE_OUT        = st_r.sda_oe;
  assign BUSY_OUT          = st_r.busy;
  assign ADDR_PTR_OUT      = st_r.ptr;
  assign ARRAY_RD_ADDR_OUT = st_r.ptr;
endmodule

/* verif/sewp_master.sv */
module sewp_master (
  // Timing reference
  input  wire logic clk_in,
  // Bus lines as seen on the wire
  output logic      scl_out,
  output logic      sda_out,
  input  wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bus idles with both lines high.
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Data is moved a little after the clock falls, never with it.
  task automatic start();
    tick(2);
    sda_out = 1'b1;
    tick(3);
    scl_out = 1'b1;
    tick(5);
    sda_out = 1'b0;
    tick(5);
    scl_out = 1'b0;
  endtask

  task automatic stop();
    tick(2);
    sda_out = 1'b0;
    tick(3);
    scl_out = 1'b1;
    tick(5);
    sda_out = 1'b1;
    tick(10);
  endtask

  // Nine pulses: eight bits MSB first and the acknowledge slot.
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      tick(2);
      sda_out = tx[i];
      tick(3);
      scl_out = 1'b1;
      tick(3);
      rx[i] = sda_in;
      tick(2);
      scl_out = 1'b0;
    end
  endtask
endmodule

/* verif/sewp_top_assertions.sv */
module sewp_top_assertions
  import sewp_pkg::*;
#(
  parameter int WRITE_CYC = SEWP_WRITE_CYC
) (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  // Bus
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_OUT,
  // Array and status
  input wire logic ARRAY_WR_VALID_OUT,
  input wire logic BUSY_OUT
);
  timeunit 1ns;
  timeprecision 1ps;

  // The write time is far beyond a delay range, so it is counted.
  // Frozen cycles are not counted, since the timer stands still then.
  logic [31:0] busy_cnt_r;
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
      busy_cnt_r <= 32'h0;
    else
      busy_cnt_r <= BUSY_OUT ? busy_cnt_r + {31'h0, CE_IN} : 32'h0;

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  AST_NO_ACK_BUSY: assert property ($rose(SDA_OE_OUT) |-> !BUSY_OUT)
    else $error("data line pulled during write cycle");
  AST_WRITE_TIME: assert property (busy_cnt_r <= WRITE_CYC)
    else $error("write cycle too long");
  AST_COMMIT_BUSY: assert property ($rose(ARRAY_WR_VALID_OUT) |-> BUSY_OUT)
    else $error("array write outside write cycle");
  AST_BUSY_AT_STOP: assert property ($rose(BUSY_OUT) |-> $past(SCL_IN, 2) && SDA_IN)
    else $error("write cycle began without stop");
  AST_ACK_HOLD: assert property ($fell(SDA_OE_OUT) |-> !$past(SCL_IN, 2))
    else $error("pull released with clock high");
  AST_DRIVE_LOW_CLK: assert property ($rose(SDA_OE_OUT) |-> !$past(SCL_IN, 2))
    else $error("pull begun with clock high");
  AST_DRIVE_ZERO: assert property (SDA_OE_OUT |-> !SDA_OUT)
    else $error("driven data not low");
  AST_QUIET_STOP: assert property (SCL_IN && $rose(SDA_IN) |-> !SDA_OE_OUT [*4])
    else $error("data line pulled after stop");
endmodule

bind sewp_top sewp_top_assertions #(.WRITE_CYC(WRITE_CYC)) chk (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN), .CE_IN(CE_IN),
  .SCL_IN(SCL_IN),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT),
  .ARRAY_WR_VALID_OUT(ARRAY_WR_VALID_OUT), .BUSY_OUT(BUSY_OUT)
);

/* verif/sewp_top_test.sv */
module sewp_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sewp_pkg::*;

  localparam int WCYC = 200;
  logic                   sys_clk, rst_n, ce, scl, sda_m, sda_w, sda_out;
  logic                   sda_oe, wp, ready, wr_valid, busy;
  logic [2:0]             sel;
  logic [8:0]             rx;
  logic [SEWP_ADDR_W-1:0] rd_addr, ptr;
  logic [SEWP_DATA_W-1:0] rd_data;
  sewp_word_type          wr_word;
  sewp_word_type          wq[$];
  int                     num_errors, samples_checked, k;

  // Open-drain wire with pull-up.
  assign sda_w = sda_m & (sda_oe ? sda_out : 1'b1);
  assign rd_data = rd_addr[7:0] ^ 8'h5a;

  sewp_top #(.WRITE_CYC(WCYC)) uut (
    .SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n), .CE_IN(ce),
    .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE_OUT(sda_oe),
    .WRITE_PROTECT_IN(wp), .UNUSED_SELECT_PIN_0_IN(sel[0]),
    .UNUSED_SELECT_PIN_1_IN(sel[1]), .UNUSED_SELECT_PIN_2_IN(sel[2]),
    .ARRAY_WR_OUT(wr_word), .ARRAY_WR_VALID_OUT(wr_valid),
    .ARRAY_WR_READY_IN(ready), .ARRAY_RD_ADDR_OUT(rd_addr),
    .ARRAY_RD_DATA_IN(rd_data), .BUSY_OUT(busy), .ADDR_PTR_OUT(ptr)
  );
  sewp_master m (.clk_in(sys_clk), .scl_out(scl), .sda_out(sda_m),
    .sda_in(sda_w));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (wr_valid && ready && ce)
      wq.push_back(wr_word);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The master releases the line in the slot; a low there is the ack.
  task automatic wb(input logic [7:0] b, input logic ack_n);
    m.xfer({b, 1'b1}, rx);
    chk(rx[0], ack_n);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wait_idle();
    for (int n = 0; busy !== 1'b0; n++) begin
      if (n == 1000) begin
        num_errors++;
        conclude();
      end
      @(negedge sys_clk);
    end
  endtask

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    wp = 1'b0;
    ready = 1'b0;
    sel = 3'h7;
    num_errors = 0;
    samples_checked = 0;
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    m.start();
    wb(8'h50, 1'b1);
    wb(8'ha0, 1'b1);
    m.stop();
    sel = 3'h2;
    m.start();
    wb(8'ha6, 1'b0);
    wb(8'h1e, 1'b0);
    for (int i = 0; i < 18; i++) begin
      wb(8'h10 + i[7:0], 1'b0);
    end
    chk(wq.size(), 0);
    chk(ptr, 11'h310);
    m.stop();
    m.start();
    wb(8'ha6, 1'b1);
    m.stop();
    // Stall the sink so that the queue of array writes backs up.
    repeat (32) @(negedge sys_clk);
    // With the enable low a ready sink must see the head word stand.
    ce = 1'b0;
    ready = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk(wr_valid, 1'b1);
    chk(wr_word, {7'h31, 4'h0, 8'h12});
    ce = 1'b1;
    wait_idle();
    chk(wq.size(), 16);
    for (int s = 0; s < 16; s++) begin
      k = (s + 2) % 16;
      if (k < 2)
        k += 16;
      chk(wq[s], {7'h31, s[3:0], 8'h10 + k[7:0]});
    end
    wp = 1'b1;
    sel = 3'h5;
    m.start();
    wb(8'ha0, 1'b0);
    wb(8'h05, 1'b0);
    wb(8'h77, 1'b0);
    m.stop();
    repeat (20) @(negedge sys_clk);
    chk(busy, 1'b0);
    chk(wq.size(), 16);
    wp = 1'b0;
    // A single byte away from slot 0 must leave with its own address.
    m.start();
    wb(8'ha0, 1'b0);
    wb(8'h05, 1'b0);
    wb(8'h3c, 1'b0);
    m.stop();
    wait_idle();
    chk(wq.size(), 17);
    chk(wq[16], {11'h005, 8'h3c});
    chk(ptr, 11'h006);
    m.start();
    wb(8'ha2, 1'b0);
    wb(8'h40, 1'b0);
    m.start();
    wb(8'ha3, 1'b0);
    m.xfer(9'h1fe, rx);
    chk(rx[8:1], 8'h1a);
    m.xfer(9'h1ff, rx);
    chk(rx[8:1], 8'h1b);
    repeat (5) @(negedge sys_clk);
    chk(sda_oe, 1'b0);
    m.stop();
    chk(ptr, 11'h142);
    conclude();
  end
endmodule
